// [dv/xdat_mem_model.sv]
module xdat_mem_model import xdat_pkg::*; (
  // Clock.
  input  wire logic       aclk,
  // Block pins.
  input  xdat_ext_t       ext_o,
  output wire logic [7:0] ext_din,
  output wire logic       port4_bit0_n,
  // Strobe clocks during which wait is held.
  input  wire logic [7:0] hold
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] width_q = 8'h00;
  wire        strobe = !ext_o.rd_n || !ext_o.wr_n;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
  end

  // A bus not being read shows the inverse, so a late capture cannot match by luck.
  assign ext_din = ext_o.rd_n ? ~mem[ext_o.addr] : mem[ext_o.addr];
  // Wait is held for as long as the peripheral needs, then released.
  assign port4_bit0_n = !(strobe && cnt_q < hold);

  always @(posedge aclk) begin
    if (strobe) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (cnt_q != 8'h00) begin
      width_q <= cnt_q;
      cnt_q <= 8'h00;
    end
    if (!ext_o.wr_n) begin
      mem[ext_o.addr] <= ext_o.dout;
    end
  end
endmodule

// [dv/xdat_timing_properties.sv]
module xdat_timing_properties import xdat_pkg::*; (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes.
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // External memory pins.
  input xdat_ext_t        ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe length counter; waits beyond 255 clocks would wrap it.
  logic [7:0] low_q;
  wire        strobe_low = !ext_o.rd_n || !ext_o.wr_n;
  always_ff @(posedge aclk) begin
    if (!aresetn || !strobe_low) begin
      low_q <= 8'h00;
    end else begin
      low_q <= low_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  one_strobe_a: assert property (ext_o.rd_n || ext_o.wr_n)
    else $error("both strobes low");
  strobe_width_a: assert property ((!strobe_low && low_q != 8'h00) |->
    (low_q[1:0] == 2'h2 || low_q[1:0] == 2'h0)) else $error("strobe width off the grid");
  addr_first_a: assert property (($fell(ext_o.rd_n) || $fell(ext_o.wr_n)) |->
    $stable(ext_o.addr)) else $error("address moved with strobe");
  addr_hold_a: assert property (strobe_low |=> !strobe_low || $stable(ext_o.addr))
    else $error("address moved under strobe");
  data_hold_a: assert property (!ext_o.wr_n |=> ext_o.wr_n || $stable(ext_o.dout))
    else $error("write data moved under strobe");
  drive_hold_a: assert property ((!ext_o.wr_n || $rose(ext_o.wr_n)) |-> ext_o.dout_oe)
    else $error("data not driven around write strobe");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_block_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
endmodule

bind xdat_timing xdat_timing_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .ext_o(ext_o));

// [dv/xdat_timing_tb.sv]
`include "xdat_defines.svh"

module xdat_timing_tb import xdat_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] ext_din, hold;
  logic port4_bit0_n;
  xdat_ext_t ext_o;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;

  xdat_timing uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_o, .ext_din, .port4_bit0_n);
  xdat_mem_model mdl (.aclk, .ext_o, .ext_din, .port4_bit0_n, .hold);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Called just after a rising edge; ready is looked at where it is settled.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = s_axi_awready && !ad;
      wh = s_axi_wready && !wd;
      @(posedge aclk);
      if (ah) begin ad = 1; s_axi_awvalid <= 1'b0; end
      if (wh) begin wd = 1; s_axi_wvalid <= 1'b0; end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (ah !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(negedge aclk); h = s_axi_arready; @(posedge aclk); end while (h !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (h !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axw(ba(idx), d, r);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(ba(idx), d, r);
    chk(nm, exp, d);
  endtask

  // One move: start it, poll until idle, judge pins, memory and status.
  task automatic mv(input logic w, dp, input logic [7:0] wd, input logic [15:0] ea,
                    input int cy, wid);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    n = 0;
    axw(ba(`XD_IDX_CMD), {16'h0000, wd, 5'h00, dp, w, 1'b1}, r);
    do begin axr(ba(`XD_IDX_STAT), s, r); n++; end while (s[0] !== 1'b0 && n < 60);
    chk("cycles", cy, {16'h0000, s[31:16]});
    chk("width", wid, {24'h0, mdl.width_q});
    chk("addr", {16'h0000, ea}, {16'h0000, ext_o.addr});
    if (w) chk("mem", {24'h0, wd}, {24'h0, mdl.mem[ea]});
    else chk("rbyte", {24'h0, mdl.mem[ea]}, {24'h0, s[15:8]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdchk("stretch", `XD_IDX_CLKCTRL, 32'h0000_0001);
    rdchk("psel", `XD_IDX_PSEL, 32'h0000_0000);
    rdchk("memmap", `XD_IDX_MEMMAP, 32'h0000_0000);
    axr(12'h000, d, r);
    chk("unmapped rd", {30'h0, `XD_RESP_SLVERR}, {d[29:0], r});
    axw(12'h004, 32'hFFFF_FFFF, r);
    chk("unmapped wr", {30'h0, `XD_RESP_SLVERR}, {30'h0, r});
    wr(`XD_IDX_PSEL, 32'h0000_00FF);
    rdchk("psel", `XD_IDX_PSEL, 32'h0000_0001);
  endtask

  task automatic t_stretch();
    wr(`XD_IDX_DPTR0, 32'h0000_1357);
    wr(`XD_IDX_SECOND_DATA_POINTER, 32'h0000_2468);
    for (int st = 0; st < 8; st++) begin
      wr(`XD_IDX_CLKCTRL, st);
      wr(`XD_IDX_PSEL, st & 1);
      rdchk("stretch", `XD_IDX_CLKCTRL, st);
      mv(1'b0, 1'b1, 8'h00, st[0] ? 16'h2468 : 16'h1357, 2 + st, st == 0 ? 2 : 4 * st);
    end
  endtask

  task automatic t_indirect();
    wr(`XD_IDX_PORT2, 32'h0000_0012);
    wr(`XD_IDX_WREG, 32'h0000_0034);
    wr(`XD_IDX_CLKCTRL, 32'h0000_0000);
    mv(1'b1, 1'b0, 8'hC3, 16'h1234, 2, 2);
    wr(`XD_IDX_CLKCTRL, 32'h0000_0003);
    mv(1'b1, 1'b0, 8'h3C, 16'h1234, 5, 12);
  endtask

  task automatic t_wait();
    wr(`XD_IDX_PSEL, 32'h0000_0000);
    wr(`XD_IDX_CLKCTRL, 32'h0000_0001);
    hold <= 8'h08;
    mv(1'b0, 1'b1, 8'h00, 16'h1357, 3, 4);
    wr(`XD_IDX_MEMMAP, 32'h0000_0080);
    rdchk("memmap", `XD_IDX_MEMMAP, 32'h0000_0000);
    wr(`XD_IDX_TAKEY, {24'h0, `XD_TA_KEY1});
    wr(`XD_IDX_TAKEY, {24'h0, `XD_TA_KEY2});
    wr(`XD_IDX_MEMMAP, 32'h0000_0080);
    rdchk("memmap", `XD_IDX_MEMMAP, 32'h0000_0080);
    mv(1'b0, 1'b1, 8'h00, 16'h1357, 5, 12);
    wr(`XD_IDX_CLKCTRL, 32'h0000_0002);
    hold <= 8'h0C;
    mv(1'b0, 1'b1, 8'h00, 16'h1357, 6, 16);
    hold <= 8'h00;
    mv(1'b0, 1'b1, 8'h00, 16'h1357, 4, 8);
    wr(`XD_IDX_CLKCTRL, 32'h0000_0000);
    hold <= 8'h04;
    mv(1'b0, 1'b1, 8'h00, 16'h1357, 3, 6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // The full run needs well under a thousand clocks; the ceiling of 20000 leaves ample room.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    hold = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_stretch();
    t_indirect();
    t_wait();
    conclude();
  end
endmodule

// [rtl/xdat_axil.sv]
`include "xdat_defines.svh"

module xdat_axil import xdat_pkg::*; (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address and data.
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  // Write response.
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  // Read address and data.
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  // Register file side.
  output xdat_regwr_t      reg_wr,
  output wire logic [7:0]  rd_idx,
  input  wire logic [31:0] rd_data
);

  logic        aw_have_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic        rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        do_wr;

  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign do_wr   = aw_have_q && w_have_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign rd_idx  = araddr[9:2];

  assign reg_wr.we   = do_wr && xdat_addr_valid(awaddr_q);
  assign reg_wr.idx  = awaddr_q[9:2];
  assign reg_wr.data = wdata_q;
  assign reg_wr.strb = wstrb_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Address and data are taken in either order and held until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `XD_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= xdat_addr_valid(awaddr_q) ? `XD_RESP_OKAY : `XD_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reads answer one clock after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `XD_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= xdat_addr_valid(araddr) ? `XD_RESP_OKAY : `XD_RESP_SLVERR;
      rdata_q  <= xdat_addr_valid(araddr) ? rd_data : 32'h0000_0000;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// [rtl/xdat_defines.svh]
`ifndef XDAT_DEFINES_SVH
`define XDAT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address on the bus is four times the index.
`define XD_IDX_DPTR0   8'h82
`define XD_IDX_SECOND_DATA_POINTER   8'h84
`define XD_IDX_PSEL    8'h86
`define XD_IDX_CLKCTRL 8'h8E
`define XD_IDX_PORT2   8'hA0
`define XD_IDX_TAKEY   8'hC7
`define XD_IDX_MEMMAP  8'hD1
`define XD_IDX_WREG    8'hF0
`define XD_IDX_CMD     8'hF1
`define XD_IDX_STAT    8'hF2

////////////////////////////////////////////////////////////////////////////////
// Field positions and reset values.
`define XD_STRETCH_MSB 2
`define XD_STRETCH_RST 3'h1
`define XD_WAITEN_BIT  7
`define XD_PSEL_BIT    0
`define XD_CMD_GO_BIT  0
`define XD_CMD_WR_BIT  1
`define XD_CMD_DP_BIT  2
`define XD_STAT_BUSY   0
`define XD_STAT_WAIT   1

////////////////////////////////////////////////////////////////////////////////
// Timing: phases of a four-clock machine cycle and the key window.
`define XD_PH_C1       2'h0
`define XD_PH_C2       2'h1
`define XD_PH_C3       2'h2
`define XD_PH_C4       2'h3
`define XD_TA_KEY1     8'hAA
`define XD_TA_KEY2     8'h55
`define XD_TA_WINDOW   6'h20

////////////////////////////////////////////////////////////////////////////////
// Bus responses.
`define XD_RESP_OKAY   2'h0
`define XD_RESP_SLVERR 2'h2

`endif

// [rtl/xdat_pkg.sv]
`include "xdat_defines.svh"

package xdat_pkg;

  typedef enum logic [1:0] {
    XD_IDLE   = 2'b00,
    XD_FETCH  = 2'b01,
    XD_ACCESS = 2'b10
  } xdat_state_t;

  // External data memory pins.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        dout_oe;
    logic        rd_n;
    logic        wr_n;
  } xdat_ext_t;

  // One register write from the bus.
  typedef struct packed {
    logic        we;
    logic [7:0]  idx;
    logic [31:0] data;
    logic [3:0]  strb;
  } xdat_regwr_t;

  function automatic logic xdat_addr_valid(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a[11:10] == 2'h0) begin
      case (a[9:2])
        `XD_IDX_DPTR0, `XD_IDX_SECOND_DATA_POINTER, `XD_IDX_PSEL, `XD_IDX_CLKCTRL,
        `XD_IDX_PORT2, `XD_IDX_TAKEY, `XD_IDX_MEMMAP, `XD_IDX_WREG,
        `XD_IDX_CMD, `XD_IDX_STAT: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

endpackage

// [rtl/xdat_timing.sv]
// The register offsets and the AXI4-Lite register port were decided locally.
`include "xdat_defines.svh"

// Summary of operation
// R1: A move spends one four-clock fetch cycle, then drives the address and accesses memory.
// R2: Bits 2-0 of clock_ctrl_sfr pick a stretch of 0 to 7, giving moves of 2 to 9 cycles.
// R3: The stretch only lengthens the external data move and nothing else.
// R4: The stretch field resets to 1, and software may write 0 for the fastest move.
// R5: The strobe lasts 2 clocks at stretch 0 and 4 clocks per step above that.
// R6: The wait input is port4_bit0 and works only while wait_input_enable is set.
// R7: With waits on, the stretch is the least length and the wait is sampled in the third state.
// R8: Each recognised wait inserts one more machine cycle into the move.
// R9: The peripheral holds wait as long as it needs and releases it to end the move.
// R10: wait_input_enable is written only through the timed_access_key procedure.
// R11: A register-indirect move takes its low address byte from the working register and its high byte from port 2.
// R12: Bit 0 of pointer_select chooses the first or second data pointer; its other bits read 0.
// R13: Address and write data stay steady until the strobe is released.
module xdat_timing import xdat_pkg::*; (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite register bus.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External data memory.
  output xdat_ext_t        ext_o,
  input  wire logic [7:0]  ext_din,
  input  wire logic        port4_bit0_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus and timed access lock.
  xdat_regwr_t reg_wr;
  logic [7:0]  rd_idx;
  logic [31:0] rd_data;
  logic        ta_open;
  logic        memmap_wr;

  xdat_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .reg_wr  (reg_wr),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  assign memmap_wr = reg_wr.we && reg_wr.idx == `XD_IDX_MEMMAP && reg_wr.strb[0];

  xdat_tkey u_tkey (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .key_wr   (reg_wr.we && reg_wr.idx == `XD_IDX_TAKEY && reg_wr.strb[0]),
    .key_data (reg_wr.data[7:0]),
    .consume  (memmap_wr),
    .open     (ta_open)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.
  logic [2:0]  stretch_select_q;
  logic        wait_input_enable_q;
  logic        pointer_select_q;
  logic [15:0] dptr0_q;
  logic [15:0] second_data_pointer_q;
  logic [7:0]  port2_q;
  logic [7:0]  wreg_q;
  logic [7:0]  cmd_wdata_q;
  logic        cmd_go;

  function automatic logic hit(input xdat_regwr_t w, input logic [7:0] idx, input int b);
    return w.we && w.idx == idx && w.strb[b];
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stretch_select_q <= `XD_STRETCH_RST; // R4
    end else if (hit(reg_wr, `XD_IDX_CLKCTRL, 0)) begin
      stretch_select_q <= reg_wr.data[`XD_STRETCH_MSB:0]; // R2
    end
  end

  // Writes outside the unlock window are dropped without an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_input_enable_q <= 1'b0;
    end else if (memmap_wr && ta_open) begin
      wait_input_enable_q <= reg_wr.data[`XD_WAITEN_BIT]; // R10
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pointer_select_q <= 1'b0;
    end else if (hit(reg_wr, `XD_IDX_PSEL, 0)) begin
      pointer_select_q <= reg_wr.data[`XD_PSEL_BIT]; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dptr0_q <= 16'h0000;
      second_data_pointer_q <= 16'h0000;
    end else begin
      if (hit(reg_wr, `XD_IDX_DPTR0, 0)) dptr0_q[7:0] <= reg_wr.data[7:0];
      if (hit(reg_wr, `XD_IDX_DPTR0, 1)) dptr0_q[15:8] <= reg_wr.data[15:8];
      if (hit(reg_wr, `XD_IDX_SECOND_DATA_POINTER, 0)) second_data_pointer_q[7:0] <= reg_wr.data[7:0];
      if (hit(reg_wr, `XD_IDX_SECOND_DATA_POINTER, 1)) second_data_pointer_q[15:8] <= reg_wr.data[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port2_q <= 8'h00;
      wreg_q  <= 8'h00;
    end else begin
      if (hit(reg_wr, `XD_IDX_PORT2, 0)) port2_q <= reg_wr.data[7:0];
      if (hit(reg_wr, `XD_IDX_WREG, 0)) wreg_q <= reg_wr.data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Move sequencer: one fetch cycle, then 1 + stretch access cycles plus waits.
  xdat_state_t state_q;
  logic [1:0]  phase_q;
  logic [2:0]  left_q;
  logic [2:0]  str_lat_q;
  logic        first_q;
  logic        hold_q;
  logic        is_wr_q;
  logic [15:0] addr_lat_q;
  logic [15:0] cycles_q;
  logic [7:0]  rdata_q;
  logic        last;
  logic        start_ok;
  logic        stb_now;
  logic        cyc_end;

  assign cmd_go  = hit(reg_wr, `XD_IDX_CMD, 0) && reg_wr.data[`XD_CMD_GO_BIT] &&
                   state_q == XD_IDLE;
  assign last    = (left_q == 3'h0);
  assign cyc_end = (phase_q == `XD_PH_C4);

  // Strobe window: C4 of the first access cycle up to C3 of the last one,
  // or C2 and C3 alone when no stretch is set.
  always_comb begin
    start_ok = 1'b1;
    if (first_q) begin
      start_ok = (str_lat_q == 3'h0) ? (phase_q != `XD_PH_C1) : cyc_end;
    end
    stb_now = state_q == XD_ACCESS && start_ok &&
              (!last || phase_q != `XD_PH_C4 || hold_q); // R5
  end

  // The stretch is latched at the start so a write during a move cannot
  // change its length halfway through.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      str_lat_q   <= 3'h0;
      is_wr_q     <= 1'b0;
      addr_lat_q  <= 16'h0000;
      cmd_wdata_q <= 8'h00;
    end else if (cmd_go) begin
      str_lat_q   <= stretch_select_q;
      is_wr_q     <= reg_wr.data[`XD_CMD_WR_BIT];
      cmd_wdata_q <= reg_wr.data[15:8];
      if (reg_wr.data[`XD_CMD_DP_BIT]) begin
        addr_lat_q <= pointer_select_q ? second_data_pointer_q : dptr0_q; // R12
      end else begin
        addr_lat_q <= {port2_q, wreg_q}; // R11
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= XD_IDLE;
      phase_q <= `XD_PH_C1;
      left_q  <= 3'h0;
      first_q <= 1'b0;
    end else begin
      case (state_q)
        XD_IDLE: begin
          phase_q <= `XD_PH_C1;
          if (cmd_go) state_q <= XD_FETCH;
        end
        XD_FETCH: begin
          phase_q <= phase_q + 2'h1;
          if (cyc_end) begin
            state_q <= XD_ACCESS; // R1
            left_q  <= str_lat_q; // R2 R3
            first_q <= 1'b1;
          end
        end
        XD_ACCESS: begin
          phase_q <= phase_q + 2'h1;
          if (cyc_end) begin
            first_q <= 1'b0;
            if (!last) begin
              left_q <= left_q - 3'h1;
            end else if (!hold_q) begin
              state_q <= XD_IDLE; // R9
            end
          end
        end
        default: begin
          state_q <= XD_IDLE;
        end
      endcase
    end
  end

  // Wait is looked at in C3 of the closing cycle, before the strobe rises.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 1'b0;
    end else if (state_q == XD_ACCESS && last && phase_q == `XD_PH_C3) begin
      hold_q <= wait_input_enable_q && !port4_bit0_n; // R6 R7 R8
    end else if (cyc_end) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycles_q <= 16'h0000;
    end else if (cmd_go) begin
      cycles_q <= 16'h0000;
    end else if (state_q != XD_IDLE && cyc_end) begin
      cycles_q <= cycles_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins. The strobe is registered, so it trails the window by one clock;
  // address and data are held past it until the fetch cycle of the next move ends.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_o.addr <= 16'h0000;
      ext_o.dout <= 8'h00;
    end else if (state_q == XD_FETCH && cyc_end) begin
      ext_o.addr <= addr_lat_q; // R1 R13
      ext_o.dout <= cmd_wdata_q; // R13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_o.rd_n    <= 1'b1;
      ext_o.wr_n    <= 1'b1;
      ext_o.dout_oe <= 1'b0;
    end else begin
      ext_o.rd_n    <= !(stb_now && !is_wr_q); // R5
      ext_o.wr_n    <= !(stb_now && is_wr_q); // R5
      ext_o.dout_oe <= (state_q == XD_ACCESS && is_wr_q) || !ext_o.wr_n; // R13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 8'h00;
    end else if (!ext_o.rd_n && !stb_now) begin
      rdata_q <= ext_din;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      `XD_IDX_CLKCTRL: rd_data[`XD_STRETCH_MSB:0] = stretch_select_q;
      `XD_IDX_MEMMAP:  rd_data[`XD_WAITEN_BIT] = wait_input_enable_q;
      `XD_IDX_PSEL:    rd_data[`XD_PSEL_BIT] = pointer_select_q; // R12
      `XD_IDX_DPTR0:   rd_data[15:0] = dptr0_q;
      `XD_IDX_SECOND_DATA_POINTER:   rd_data[15:0] = second_data_pointer_q;
      `XD_IDX_PORT2:   rd_data[7:0] = port2_q;
      `XD_IDX_WREG:    rd_data[7:0] = wreg_q;
      `XD_IDX_CMD:     rd_data[15:8] = cmd_wdata_q;
      `XD_IDX_STAT: begin
        rd_data[`XD_STAT_BUSY] = (state_q != XD_IDLE);
        rd_data[`XD_STAT_WAIT] = hold_q;
        rd_data[15:8]          = rdata_q;
        rd_data[31:16]         = cycles_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

endmodule

// [rtl/xdat_tkey.sv]
`include "xdat_defines.svh"

module xdat_tkey import xdat_pkg::*; (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Key register writes and protected write use.
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       consume,
  output wire logic       open
);

  logic       armed_q;
  logic [5:0] win_q;

  assign open = (win_q != 6'h00);

  // The two key bytes must arrive as consecutive key writes; any other byte
  // disarms, so a stray write cannot leave the lock half open.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (key_wr) begin
      armed_q <= (key_data == `XD_TA_KEY1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_q <= 6'h00;
    end else if (key_wr && armed_q && key_data == `XD_TA_KEY2) begin
      win_q <= `XD_TA_WINDOW;
    end else if (consume) begin
      win_q <= 6'h00;
    end else if (win_q != 6'h00) begin
      win_q <= win_q - 6'h01;
    end
  end

endmodule
